// File: sacc_top.sv
// Cycle control, serial result shifter and conversion timing of the serial converter.
`timescale 1ns/10ps
`include "sacc_regs.svh"
// Function
// - Select fall with strobe high starts cycle.
// - Top bit ready for first falling clock.
// - Output bit changes only on rising clock or on the load at cycle start.
// - Strobe rise under select low begins cycle.
// - Strobe fall starts sampling, any clock level.
// - Strobe rise releases top bit to output.
// - Select-only variant drives top bit on fall.
// - Result is unipolar straight binary code.
// - Result saturates at both rails.
// - Sleep after conversion, wake on start edge.
// - Approximation runs a fixed 20 oscillator ticks.
// - Output carries previous cycle's result.
// - Cut or initialization cycle gives special code.
// - Result in bits 15 to 2.
// - Sampling spans 20 clocks from fifth.
module sacc_top (
  input logic mclk,
  input logic reset_n,
  input logic select_n,
  input logic frame_strobe,
  input logic sclk,
  input logic cmp_above,
  output logic serial_result_out,
  output logic serial_result_oe,
  output logic sample_hold,
  output logic power_down,
  output sacc_pkg::sacc_code_t dac_trial,
  output logic conv_busy
);
  import sacc_pkg::*;

  localparam sacc_pins_t PINS_IDLE = '{sel_n: 1'b1, strobe: 1'b0, sclk: 1'b0, cmp: 1'b0};

  sacc_pins_t pin_meta, pin_sync, pin_last;
  logic sel_fall, sel_rise, fs_rise, fs_fall, sclk_rise, sclk_fall;
  logic start_sel, start_fs, start_any, special_now, use_special;
  sacc_state_t state, next_state;
  logic [4:0] edge_cnt, next_edge_cnt;
  logic force_code, next_force, next_sample_hold, next_power_down;
  logic sar_start, sar_abort;
  sacc_word_t shreg, next_shreg;
  logic oe, next_oe, seen_fall, next_seen;
  logic [3:0] rise_cnt, next_rise;
  logic [2:0] osc_cnt, next_osc;
  logic conv_tick, next_tick;
  logic res_valid, res_ready, fifo_out_valid, fifo_out_ready;
  sacc_code_t result, fifo_out_data, load_code;

  // The first stage is read only by the second, keeping metastability out of the edge logic.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pin_meta <= PINS_IDLE;
      pin_sync <= PINS_IDLE;
      pin_last <= PINS_IDLE;
    end else begin
      pin_meta <= '{sel_n: select_n, strobe: frame_strobe, sclk: sclk, cmp: cmp_above};
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  assign sel_fall = pin_last.sel_n & ~pin_sync.sel_n;
  assign sel_rise = ~pin_last.sel_n & pin_sync.sel_n;
  assign fs_rise = ~pin_last.strobe & pin_sync.strobe;
  assign fs_fall = pin_last.strobe & ~pin_sync.strobe;
  assign sclk_rise = ~pin_last.sclk & pin_sync.sclk;
  assign sclk_fall = pin_last.sclk & ~pin_sync.sclk;

  assign start_sel = sel_fall & pin_sync.strobe;
  assign start_fs = fs_rise & ~pin_sync.sel_n;
  assign start_any = start_sel | start_fs;
  assign special_now = start_any && (state == ST_CONVERT || state == ST_ACQUIRE);
  assign use_special = special_now || force_code || !fifo_out_valid;
  assign load_code = use_special ? `SACC_CODE_SPECIAL : fifo_out_data;
  assign fifo_out_ready = start_any && !special_now && !force_code;
  assign sar_abort = start_any && state == ST_CONVERT;

  always_comb begin
    next_state = state;
    next_edge_cnt = edge_cnt;
    next_force = force_code;
    next_power_down = power_down;
    sar_start = 1'b0;
    if (start_any) begin
      next_power_down = 1'b0;
      next_edge_cnt = '0;
      next_force = 1'b0;
      next_state = start_sel ? ST_ACQUIRE : ST_ARMED;
    end else begin
      case (state)
        ST_SLEEP: begin
          next_power_down = 1'b1;
        end
        ST_ARMED: begin
          if (fs_fall) begin
            next_state = ST_ACQUIRE;
          end else if (sel_rise) begin
            next_state = ST_SLEEP;
            next_power_down = 1'b1;
          end
        end
        ST_ACQUIRE: begin
          if (sel_rise) begin
            next_state = ST_SLEEP;
            next_force = 1'b1;
            next_power_down = 1'b1;
          end else if (sclk_fall) begin
            if (edge_cnt == 5'(`SACC_HOLD_EDGES - 1)) begin
              next_state = ST_CONVERT;
              sar_start = 1'b1;
            end
            next_edge_cnt = 5'(edge_cnt + 1'b1);
          end
        end
        ST_CONVERT: begin
          if (!conv_busy) begin
            next_state = ST_SLEEP;
            next_power_down = 1'b1;
          end
        end
        default: begin
          next_state = ST_SLEEP;
        end
      endcase
    end
    next_sample_hold = next_state == ST_ACQUIRE && next_edge_cnt >= 5'(`SACC_SAMPLE_FIRST);
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state <= ST_SLEEP;
      edge_cnt <= '0;
      force_code <= 1'b0;
      sample_hold <= 1'b0;
      power_down <= 1'b1;
    end else begin
      state <= next_state;
      edge_cnt <= next_edge_cnt;
      force_code <= next_force;
      sample_hold <= next_sample_hold;
      power_down <= next_power_down;
    end
  end

  always_comb begin
    next_shreg = shreg;
    next_oe = oe;
    next_rise = rise_cnt;
    next_seen = seen_fall;
    if (start_any) begin
      next_shreg = {load_code, {`SACC_PAD_BITS{1'b0}}};
      next_oe = 1'b1;
      next_rise = '0;
      next_seen = 1'b0;
    end else if (sel_rise) begin
      next_oe = 1'b0;
    end else begin
      if (sclk_fall && state != ST_ARMED) begin
        next_seen = 1'b1;
      end
      if (sclk_rise && oe && seen_fall) begin
        if (rise_cnt == 4'(`SACC_SHIFT_RISES)) begin
          next_oe = 1'b0;
        end else begin
          next_shreg = shreg << 1;
          next_rise = 4'(rise_cnt + 1'b1);
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      shreg <= '0;
      oe <= 1'b0;
      rise_cnt <= '0;
      seen_fall <= 1'b0;
    end else begin
      shreg <= next_shreg;
      oe <= next_oe;
      rise_cnt <= next_rise;
      seen_fall <= next_seen;
    end
  end

  assign serial_result_out = shreg[`SACC_WORD_BITS-1];
  assign serial_result_oe = oe;

  // The oscillator stand-in restarts with each conversion, so the first decision sees a settled comparator.
  // restart on start
  always_comb begin
    next_tick = !sar_start && osc_cnt == 3'(`SACC_OSC_DIV - 1);
    next_osc = (sar_start || next_tick) ? '0 : 3'(osc_cnt + 1'b1);
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      osc_cnt <= '0;
      conv_tick <= 1'b0;
    end else begin
      osc_cnt <= next_osc;
      conv_tick <= next_tick;
    end
  end

  sacc_sar u_sar (
    .mclk(mclk),
    .reset_n(reset_n),
    .conv_tick(conv_tick),
    .start(sar_start),
    .abort(sar_abort),
    .cmp_above(pin_sync.cmp),
    .trial(dac_trial),
    .busy(conv_busy),
    .res_valid(res_valid),
    .res_ready(res_ready),
    .result(result)
  );

  sacc_fifo #(
    .WIDTH(`SACC_RES_BITS),
    .DEPTH(`SACC_FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .reset_n(reset_n),
    .in_valid(res_valid),
    .in_ready(res_ready),
    .in_data(result),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  chk_select_start:
    assert property (@(posedge mclk) disable iff (!reset_n)
      start_sel |=> state == ST_ACQUIRE && serial_result_oe && edge_cnt == '0 && !power_down)
    else $error("Select fall with strobe high did not start a cycle.");

  chk_msb_first:
    assert property (@(posedge mclk) disable iff (!reset_n)
      start_sel && state == ST_SLEEP && !force_code && fifo_out_valid
      |=> serial_result_out == $past(fifo_out_data[`SACC_RES_BITS-1]))
    else $error("Top result bit was not presented at cycle start.");

  chk_shift_on_rise:
    assert property (@(posedge mclk) disable iff (!reset_n)
      !start_any && !sclk_rise |=> shreg == $past(shreg))
    else $error("Output word changed without a rising serial clock.");

  chk_strobe_release:
    assert property (@(posedge mclk) disable iff (!reset_n)
      start_fs |=> state == ST_ARMED && serial_result_oe && !power_down)
    else $error("Strobe rise did not release the top bit.");

  chk_strobe_fall_start:
    assert property (@(posedge mclk) disable iff (!reset_n)
      state == ST_ARMED && fs_fall && !start_any |=> state == ST_ACQUIRE && edge_cnt == '0)
    else $error("Strobe fall did not begin sampling.");

  chk_sample_start:
    assert property (@(posedge mclk) disable iff (!reset_n)
      state == ST_ACQUIRE && sclk_fall && edge_cnt == 5'h3 && !sel_rise && !start_any |=> sample_hold)
    else $error("Sampling did not begin at the fifth clock.");

  chk_hold_convert:
    assert property (@(posedge mclk) disable iff (!reset_n)
      state == ST_ACQUIRE && sclk_fall && edge_cnt == 5'h17 && !sel_rise && !start_any
      |=> state == ST_CONVERT && conv_busy && !sample_hold)
    else $error("Conversion did not start after the 24th falling edge.");

  chk_cut_code:
    assert property (@(posedge mclk) disable iff (!reset_n)
      state == ST_CONVERT && start_sel |=> shreg[`SACC_WORD_BITS-1:`SACC_PAD_BITS] == `SACC_CODE_SPECIAL)
    else $error("Cut conversion did not yield the special code.");

  chk_auto_sleep:
    assert property (@(posedge mclk) disable iff (!reset_n)
      state == ST_CONVERT && !conv_busy && !start_any |=> power_down && state == ST_SLEEP)
    else $error("Device did not power down after conversion.");

  chk_word_end:
    assert property (@(posedge mclk) disable iff (!reset_n)
      oe && sclk_rise && seen_fall && rise_cnt == 4'hf && !start_any && !sel_rise |=> !serial_result_oe)
    else $error("Output not released after the last word bit.");
endmodule

// File: sacc_regs.svh
// Timing counts, result codes and word layout for the serial converter control.
`ifndef SACC_REGS_SVH
`define SACC_REGS_SVH
`define SACC_CLK_PERIOD_NS 20
`define SACC_OSC_PERIOD_NS 100
`define SACC_OSC_DIV ((`SACC_OSC_PERIOD_NS + `SACC_CLK_PERIOD_NS - 1) / `SACC_CLK_PERIOD_NS)
`define SACC_CONV_CLOCKS 20
`define SACC_RES_BITS 14
`define SACC_PAD_BITS 2
`define SACC_WORD_BITS 16
`define SACC_SHIFT_RISES 15
`define SACC_HOLD_EDGES 24
`define SACC_SAMPLE_FIRST 4
`define SACC_FIFO_DEPTH 4
`define SACC_CODE_SPECIAL 14'h3fc0
`define SACC_CODE_ZERO 14'h0000
`define SACC_CODE_FULL 14'h3fff
`endif

// File: sacc_pkg.sv
// Types shared by the serial converter control modules.
`include "sacc_regs.svh"
package sacc_pkg;
  typedef logic [`SACC_RES_BITS-1:0] sacc_code_t;
  typedef logic [`SACC_WORD_BITS-1:0] sacc_word_t;
  typedef enum logic [1:0] {ST_SLEEP, ST_ARMED, ST_ACQUIRE, ST_CONVERT} sacc_state_t;
  typedef struct packed {
    logic sel_n;
    logic strobe;
    logic sclk;
    logic cmp;
  } sacc_pins_t;
endpackage

// File: sacc_fifo.sv
// Result buffer between the converter and the serial output shifter.
`timescale 1ns/10ps
module sacc_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 4
) (
  input logic mclk,
  input logic reset_n,
  input logic in_valid,
  output logic in_ready,
  input logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  // Pointers wrap naturally, so the depth must be a power of two.
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] fill, next_fill;
  logic push, pop;

  assign in_ready = fill != (AW+1)'(DEPTH);
  assign out_valid = fill != '0;
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
    case ({push, pop})
      2'b10: next_fill = (AW+1)'(fill + 1'b1);
      2'b01: next_fill = (AW+1)'(fill - 1'b1);
      default: next_fill = fill;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      fill <= next_fill;
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

// File: sacc_sar.sv
// Successive-approximation stepper that drives the trial code and holds the result.
`timescale 1ns/10ps
`include "sacc_regs.svh"
module sacc_sar (
  input logic mclk,
  input logic reset_n,
  input logic conv_tick,
  input logic start,
  input logic abort,
  input logic cmp_above,
  output sacc_pkg::sacc_code_t trial,
  output logic busy,
  output logic res_valid,
  input logic res_ready,
  output sacc_pkg::sacc_code_t result
);
  import sacc_pkg::*;
  logic [4:0] step, next_step;
  sacc_code_t probe, next_probe, next_trial, next_result;
  logic next_busy, next_res_valid;

  always_comb begin
    next_step = step;
    next_probe = probe;
    next_trial = trial;
    next_busy = busy;
    next_res_valid = res_valid;
    next_result = result;
    if (res_valid && res_ready) begin
      next_res_valid = 1'b0;
    end
    if (abort) begin
      next_busy = 1'b0;
      next_probe = '0;
    end else if (start) begin
      next_busy = 1'b1;
      next_step = '0;
      next_probe = {1'b1, {(`SACC_RES_BITS-1){1'b0}}};
      next_trial = {1'b1, {(`SACC_RES_BITS-1){1'b0}}};
    end else if (busy && conv_tick) begin
      if (step == 5'(`SACC_CONV_CLOCKS - 1)) begin
        // A full buffer stalls the finish rather than losing a result.
        if (!res_valid || res_ready) begin
          next_busy = 1'b0;
          next_res_valid = 1'b1;
          next_result = trial;
        end
      end else begin
        next_step = 5'(step + 1'b1);
        next_trial = (cmp_above ? trial : (trial & ~probe)) | (probe >> 1);
        next_probe = probe >> 1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      step <= '0;
      probe <= '0;
      trial <= `SACC_CODE_ZERO;
      busy <= 1'b0;
      res_valid <= 1'b0;
      result <= `SACC_CODE_ZERO;
    end else begin
      step <= next_step;
      probe <= next_probe;
      trial <= next_trial;
      busy <= next_busy;
      res_valid <= next_res_valid;
      result <= next_result;
    end
  end

  chk_conv_start:
    assert property (@(posedge mclk) disable iff (!reset_n)
      start && !abort |=> busy && trial == {1'b1, {(`SACC_RES_BITS-1){1'b0}}} ##1 busy)
    else $error("Conversion did not start with the top trial bit.");

  chk_bit_keep:
    assert property (@(posedge mclk) disable iff (!reset_n)
      busy && conv_tick && !abort && !start && cmp_above && probe != '0 |=> (trial & $past(probe)) != '0)
    else $error("A bit the comparator accepted was dropped.");
endmodule

// File: sacc_host.sv
// Host serial port model: frames a cycle, clocks the link and gathers the result word.
`timescale 1ns/10ps
module sacc_host (
  input logic serial_result_out,
  input logic serial_result_oe,
  input logic sample_hold,
  input logic power_down,
  output logic select_n,
  output logic frame_strobe,
  output logic sclk
);
  initial begin
    select_n = 1'b1;
    frame_strobe = 1'b1;
    sclk = 1'b0;
  end
  // Mode 0 frames with select, strobe held high; mode 1 holds select low and frames with the strobe.
  // The odd offset keeps link edges off the system clock edges.
  task automatic frame(input int mode, input int edges, output logic [15:0] word, output logic [3:0] seen);
    word = '0;
    seen = '0;
    #163;
    if (mode != 0) begin
      frame_strobe = 1'b0;
      select_n = 1'b0;
      #160 frame_strobe = 1'b1;
      #160 frame_strobe = 1'b0;
    end else begin
      select_n = 1'b0;
    end
    #160;
    for (int i = 1; i <= edges; i++) begin
      sclk = 1'b1;
      #100 sclk = 1'b0;
      if (i <= 16) word = {word[14:0], serial_result_out};
      if (i == 1) seen[0] = serial_result_oe;
      if (i == 1) seen[3] = power_down;
      if (i == 12) seen[1] = sample_hold;
      if (i == 20) seen[2] = serial_result_oe;
      #60;
    end
    #100 select_n = 1'b1;
    #160 frame_strobe = 1'b1;
  endtask
endmodule

// File: sacc_top_test.sv
// Self-checking bench for the serial converter control.
`timescale 1ns/10ps
module sacc_top_test;
  import sacc_pkg::*;
  logic mclk, reset_n, select_n, frame_strobe, sclk, cmp_above;
  logic serial_result_out, serial_result_oe, sample_hold, power_down, conv_busy;
  sacc_code_t dac_trial;
  logic [14:0] analog_input;
  logic [15:0] word, prev;
  logic [3:0] seen;
  int miscompares, compares;
  logic [14:0] levels [5] = '{15'h0000, 15'h3fff, 15'h4000, 15'h2aaa, 15'h1555};

  sacc_top DUT (
    .mclk(mclk), .reset_n(reset_n), .select_n(select_n), .frame_strobe(frame_strobe),
    .sclk(sclk), .cmp_above(cmp_above), .serial_result_out(serial_result_out),
    .serial_result_oe(serial_result_oe), .sample_hold(sample_hold), .power_down(power_down),
    .dac_trial(dac_trial), .conv_busy(conv_busy)
  );
  sacc_host host (
    .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe),
    .sample_hold(sample_hold), .power_down(power_down), .select_n(select_n),
    .frame_strobe(frame_strobe), .sclk(sclk)
  );

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Comparator stand-in; levels at or above 4000h sit above the reference.
  initial cmp_above = 1'b0;
  always @(negedge mclk) cmp_above <= analog_input >= {1'b0, dac_trial};

  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  function automatic logic [15:0] expw(input logic [14:0] lvl);
    return lvl[14] ? 16'hfffc : {lvl[13:0], 2'b00};
  endfunction
  task automatic settle();
    int n;
    n = 0;
    while (conv_busy !== 1'b0 && n < 400) begin
      @(negedge mclk);
      n++;
    end
    check("conv_done", {15'h0, conv_busy}, 16'h0000);
    repeat (3) @(negedge mclk);
    check("power_down", {15'h0, power_down}, 16'h0001);
  endtask
  task automatic cycle(input int mode, input logic [14:0] lvl, input logic [15:0] exp);
    analog_input = lvl;
    host.frame(mode, 24, word, seen);
    check("word", word, exp);
    check("oe_first", {15'h0, seen[0]}, 16'h0001);
    check("wake", {15'h0, seen[3]}, 16'h0000);
    check("hold_mid", {15'h0, seen[1]}, 16'h0001);
    check("oe_late", {15'h0, seen[2]}, 16'h0000);
    check("busy", {15'h0, conv_busy}, 16'h0001);
    check("hold_end", {15'h0, sample_hold}, 16'h0000);
    settle();
  endtask

  task automatic t_reset();
    check("idle", {12'h0, power_down, serial_result_oe, sample_hold, conv_busy}, 16'h0008);
    $display("test reset done");
  endtask
  task automatic t_init();
    host.frame(0, 4, word, seen);
    check("init_word", word, 16'h000f);
    check("init_busy", {15'h0, conv_busy}, 16'h0000);
    cycle(0, 15'h1234, 16'hff00);
    prev = expw(15'h1234);
    $display("test init done");
  endtask
  task automatic t_codes();
    for (int i = 0; i < 5; i++) begin
      cycle(0, levels[i], prev);
      prev = expw(levels[i]);
    end
    $display("test codes done");
  endtask
  task automatic t_strobe();
    cycle(1, 15'h0f0f, prev);
    cycle(1, 15'h3000, expw(15'h0f0f));
    prev = expw(15'h3000);
    $display("test strobe done");
  endtask
  task automatic t_abort();
    // The second start lands during the first conversion and cuts it.
    analog_input = 15'h0a0a;
    host.frame(0, 24, word, seen);
    check("abort_prev", word, prev);
    analog_input = 15'h0777;
    host.frame(0, 24, word, seen);
    check("abort_code", word, 16'hff00);
    settle();
    cycle(0, 15'h1111, expw(15'h0777));
    $display("test abort done");
  endtask

  initial begin
    miscompares = 0;
    compares = 0;
    analog_input = '0;
    reset_n = 1'b0;
    repeat (3) @(negedge mclk);
    reset_n = 1'b1;
    repeat (3) @(negedge mclk);
    t_reset();
    t_init();
    t_codes();
    t_strobe();
    t_abort();
    conclude();
  end
  // Watchdog well beyond the dozen frames of under 5 us each.
  initial begin
    #400000;
    miscompares++;
    conclude();
  end
endmodule
